//--- hdl/lfm_channel.sv
`default_nettype none
module lfm_channel (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Control
  input  wire logic running,
  input  wire logic masked,
  input  wire logic stable,
  input  wire logic forceOpen,
  input  wire logic hot,
  input  wire logic dimTick,
  // Monitors
  input  wire logic atTarget,
  input  wire logic shortDetect,
  // Results
  output logic      enable,
  output logic      faulted
);
  import lfm_pkg::*;

  lfm_ch_state_t state;
  lfm_ch_state_t next_state;
  logic [15:0]   hotCount;
  logic [15:0]   next_hotCount;
  logic [2:0]    dimCount;
  logic [2:0]    next_dimCount;
  logic          next_faulted;

  // ==========================================================================
  // Classification
  // ==========================================================================
  // Apparent shorts and drops below target are ignored while the loop is
  // unsettled, so a current step never knocks a good string out.
  always_comb begin
    next_state    = state;
    next_hotCount = hotCount;
    next_dimCount = dimCount;
    next_faulted  = faulted;
    if (!running || masked) begin
      if (!running) begin
        next_state = LFM_CH_UNKNOWN;
      end else begin
        next_state = LFM_CH_OFF;
      end
      next_hotCount = '0;
      next_dimCount = '0;
    end else begin
      case (state)
        LFM_CH_UNKNOWN: begin
          if (stable && shortDetect) begin
            next_state   = LFM_CH_OFF;
            next_faulted = 1'b1;
          end else if (atTarget) begin
            next_state = LFM_CH_GOOD;
          end else if (forceOpen) begin
            next_state = LFM_CH_OPEN;
          end
        end
        LFM_CH_GOOD: begin
          if (stable && shortDetect) begin
            next_state   = LFM_CH_OFF;
            next_faulted = 1'b1;
          end else if (stable && !atTarget) begin
            next_state = LFM_CH_OPEN;
          end
        end
        LFM_CH_OPEN: begin
          if (atTarget) begin
            next_state    = LFM_CH_GOOD;
            next_hotCount = '0;
            next_dimCount = '0;
          end else if (hot) begin
            next_hotCount = hotCount + 16'h0001;
            if (hotCount >= 16'(OPEN_HOT_CYC - 1)) begin
              next_state   = LFM_CH_OFF;
              next_faulted = 1'b1;
            end
          end else if (dimTick) begin
            next_dimCount = dimCount + 3'h1;
            if (dimCount >= OPEN_DIM_CYCLES - 3'h1) begin
              next_state   = LFM_CH_OFF;
              next_faulted = 1'b1;
            end
          end
        end
        LFM_CH_OFF: next_state = LFM_CH_OFF;
        default:    next_state = LFM_CH_UNKNOWN;
      endcase
    end
  end

  // Faults latch until reset so the host may read them later.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state    <= LFM_CH_UNKNOWN;
      hotCount <= '0;
      dimCount <= '0;
      faulted  <= 1'b0;
    end else begin
      state    <= next_state;
      hotCount <= next_hotCount;
      dimCount <= next_dimCount;
      faulted  <= next_faulted;
    end
  end

  assign enable = running && (state != LFM_CH_OFF);

  // Hot open time-out ends exactly at the count.
  hot_timeout_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state == LFM_CH_OPEN && hot && running && !masked && !atTarget
     && hotCount == 16'(OPEN_HOT_CYC - 1)) |=> state == LFM_CH_OFF)
    else $error("open channel not disabled at hot time-out");
endmodule // lfm_channel
`default_nettype wire

//--- hdl/lfm_fault_manager.sv
`default_nettype none
module lfm_fault_manager (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  // Analog monitors
  input  wire lfm_pkg::lfm_sense_t     sense,
  input  wire lfm_pkg::lfm_chan_sense_t chanSense,
  // Register port from the serial management bus
  input  wire logic [7:0]              regAddr,
  input  wire logic                    regWrite,
  input  wire logic [7:0]              regWdata,
  input  wire logic                    regRead,
  output logic [7:0]                   regRdata,
  // Power stage controls
  input  wire logic                    pwmOnRequest,
  output logic                         switchGate,
  output logic [11:0]                  currentLimitMa,
  output logic                         startCurrentInject,
  output logic                         inputSwitchOff,
  output logic [5:0]                   channelEnable
);
  import lfm_pkg::*;

  // ==========================================================================
  // Start-up sequencer
  // ==========================================================================
  lfm_state_t state;
  lfm_state_t next_state;
  logic       ovpArmed;
  logic       next_ovpArmed;
  logic       tripped;
  logic       next_tripped;
  logic       inputFault;
  logic       next_inputFault;
  logic       ssStart;
  logic       ssDone;
  logic [11:0] ssLimit;
  logic       running;

  // Undervoltage beats everything: the sequencer goes back to LFM_RESET; latched faults stay.
  always_comb begin
    next_state      = state;
    next_ovpArmed   = ovpArmed;
    next_tripped    = tripped;
    next_inputFault = inputFault;
    if (sense.overvoltageAbove20) begin
      next_ovpArmed = 1'b1;
    end else if (ovpArmed) begin
      next_tripped  = 1'b1;
      next_ovpArmed = 1'b0;
    end
    if (sense.inputUndervoltageLockout) begin
      next_state    = LFM_RESET;
      next_ovpArmed = 1'b0;
    end else begin
      case (state)
        LFM_RESET:     next_state = LFM_INRUSH;
        LFM_INRUSH: begin
          if (sense.inrushSwitchOn) begin
            next_state = LFM_PRECHARGE;
          end
        end
        LFM_PRECHARGE: begin
          if (sense.switchNodeAbove) begin
            next_state = LFM_SOFTSTART;
          end
        end
        LFM_SOFTSTART: begin
          if (ssDone) begin
            next_state = LFM_RUN;
          end
        end
        LFM_RUN:      next_state = LFM_RUN;
        LFM_SHUTDOWN: next_state = LFM_SHUTDOWN;
        default:      next_state = LFM_RESET;
      endcase
      if (sense.inputOverLimit && state != LFM_RESET) begin
        next_state      = LFM_SHUTDOWN;
        next_inputFault = 1'b1;
      end
      if (next_tripped) begin
        next_state = LFM_SHUTDOWN;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state      <= LFM_RESET;
      ovpArmed   <= 1'b0;
      tripped    <= 1'b0;
      inputFault <= 1'b0;
    end else begin
      state      <= next_state;
      ovpArmed   <= next_ovpArmed;
      tripped    <= next_tripped;
      inputFault <= next_inputFault;
    end
  end

  assign ssStart = (state == LFM_SOFTSTART) || (state == LFM_RUN);
  assign running = ssStart;
  assign startCurrentInject = (state == LFM_PRECHARGE);
  assign inputSwitchOff     = tripped;

  lfm_softstart u_softstart (
    .mclk    (mclk),
    .resetn  (resetn),
    .start   (ssStart),
    .slowDim (chanSense.lowDimSlow),
    .limitMa (ssLimit),
    .done    (ssDone)
  );

  // ==========================================================================
  // Cycle-by-cycle current limit
  // ==========================================================================
  // Combinational cut-off: one register stage of delay would let the
  // inductor current overshoot the limit by a full clock.
  assign switchGate = running && pwmOnRequest
                      && !sense.switchOverLimit;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      currentLimitMa <= '0;
    end else begin
      currentLimitMa <= running ? ssLimit : ILIM_STEP_MA;
    end
  end

  // ==========================================================================
  // Channels
  // ==========================================================================
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [5:0] chFaulted;
  logic [5:0] chEnable;
  logic       forceOpen;

  assign forceOpen = sense.overvoltageAtLimit || sense.tempAboveLower;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      lfm_channel u_channel (
        .mclk        (mclk),
        .resetn      (resetn),
        .running     (running && state != LFM_SHUTDOWN),
        .masked      (mask[ch]),
        .stable      (chanSense.ledStable),
        .forceOpen   (forceOpen),
        .hot         (sense.tempAboveLower),
        .dimTick     (chanSense.dimCycleTick),
        .atTarget    (chanSense.currentAtTarget[ch]),
        .shortDetect (chanSense.stringShortDetect[ch]),
        .enable      (chEnable[ch]),
        .faulted     (chFaulted[ch])
      );
    end
  endgenerate

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Mask register: host writes disable channels; a channel that fails is
  // set here too so the host can see it. A hardware set wins over a write.
  always_comb begin
    next_mask = mask;
    if (regWrite && regAddr == ADDR_MASK) begin
      next_mask = regWdata;
    end
    next_mask[5:0] = next_mask[5:0] | chFaulted;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask <= RESET_MASK;
    end else begin
      mask <= next_mask;
    end
  end

  // Status shows channel faults only for channels that failed on their own,
  // not those the host masked; faults are latched inside each channel.
  logic [7:0] faultStatus;
  assign faultStatus = {tripped, inputFault, chFaulted};

  logic [7:0] next_regRdata;
  always_comb begin
    next_regRdata = regRdata;
    if (regRead) begin
      case (regAddr)
        ADDR_FAULT: next_regRdata = faultStatus;
        ADDR_MASK:  next_regRdata = mask;
        default:    next_regRdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= RESET_FAULT;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  assign channelEnable = (state == LFM_SHUTDOWN) ? 6'h00 : chEnable;

  // ==========================================================================
  // Checks
  // ==========================================================================
  no_early_switch_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state == LFM_INRUSH || state == LFM_PRECHARGE) |-> !switchGate)
    else $error("switching before inrush done");

  current_cut_a: assert property (@(posedge mclk) disable iff (!resetn)
    sense.switchOverLimit |-> !switchGate)
    else $error("switch on above current limit");

  overcurrent_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    (sense.inputOverLimit && state != LFM_RESET
     && !sense.inputUndervoltageLockout)
    |=> channelEnable == 6'h00 && faultStatus[FLT_INPUT_BIT])
    else $error("channels alive after input overcurrent");

  input_undervoltage_lockout_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
    sense.inputUndervoltageLockout |=> state == LFM_RESET
    && !switchGate)
    else $error("no reset on undervoltage");

  precharge_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state == LFM_PRECHARGE && !sense.switchNodeAbove
     && !sense.inputUndervoltageLockout && !sense.inputOverLimit
     && !next_tripped) |=> state == LFM_PRECHARGE)
    else $error("started before switch node threshold");

  ovp_trip_a: assert property (@(posedge mclk) disable iff (!resetn)
    ($past(sense.overvoltageAbove20) && !sense.overvoltageAbove20
     && !sense.inputUndervoltageLockout)
    |=> inputSwitchOff && faultStatus[FLT_TRIP_BIT])
    else $error("input switch not tripped on falling sense");

  fault_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(chFaulted[0]) |=> mask[0])
    else $error("failed channel not shown in mask");

  fault_latch_a: assert property (@(posedge mclk) disable iff (!resetn)
    chFaulted[0] |=> chFaulted[0])
    else $error("fault bit not latched");
endmodule // lfm_fault_manager
`default_nettype wire

//--- hdl/lfm_pkg.sv
`default_nettype none
package lfm_pkg;
  // ==========================================================================
  // Sizes and register map
  // ==========================================================================
  localparam int          NUM_CH        = 6;
  localparam logic [7:0]  ADDR_FAULT    = 8'h02;
  localparam logic [7:0]  ADDR_MASK     = 8'h09;
  localparam logic [7:0]  RESET_MASK    = 8'h00;
  localparam logic [7:0]  RESET_FAULT   = 8'h00;
  // Fault register layout: bits 5..0 per channel, bit 6 input fault,
  // bit 7 input protection switch tripped.
  localparam int          FLT_INPUT_BIT = 6;
  localparam int          FLT_TRIP_BIT  = 7;

  // ==========================================================================
  // Current limit staircase, in milliamps
  // ==========================================================================
  localparam logic [11:0] ILIM_STEP_MA  = 12'h0113;   // 275 mA per step.
  localparam logic [2:0]  ILIM_LAST_STEP = 3'h7;      // Seven more steps.
  localparam logic [11:0] ILIM_FINAL_MA = 12'h0898;   // 2200 mA.

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_KHZ          = 25000;
  localparam int SS_TOTAL_US      = 8000;
  localparam int SS_STEP_CYC      = (SS_TOTAL_US * (CLK_KHZ / 1000) + 7) / 8;
  localparam int OPEN_HOT_US      = 800;
  localparam int OPEN_HOT_CYC     = OPEN_HOT_US * (CLK_KHZ / 1000);
  localparam logic [2:0] OPEN_DIM_CYCLES = 3'h6;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    LFM_RESET, LFM_INRUSH, LFM_PRECHARGE, LFM_SOFTSTART, LFM_RUN, LFM_SHUTDOWN
  } lfm_state_t;

  typedef enum logic [1:0] {
    LFM_CH_UNKNOWN, LFM_CH_GOOD, LFM_CH_OPEN, LFM_CH_OFF
  } lfm_ch_state_t;

  // Analog comparator results from the supervisory front end.
  typedef struct packed {
    logic inputUndervoltageLockout;
    logic inrushSwitchOn;
    logic switchNodeAbove;      // Switch node above the start threshold.
    logic overvoltageAtLimit;
    logic overvoltageAbove20;   // Overvoltage sense above 20 % of target.
    logic inputOverLimit;
    logic tempAboveLower;
    logic switchOverLimit;      // Switch current above present limit.
  } lfm_sense_t;

  typedef struct packed {
    logic [5:0] currentAtTarget;
    logic [5:0] stringShortDetect;
    logic       ledStable;
    logic       dimCycleTick;
    logic       lowDimSlow;     // Low dimming frequency with small duty.
  } lfm_chan_sense_t;
endpackage
`default_nettype wire

//--- hdl/lfm_softstart.sv
`default_nettype none
module lfm_softstart (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Control
  input  wire logic        start,
  input  wire logic        slowDim,
  // Result
  output logic [11:0]      limitMa,
  output logic             done
);
  import lfm_pkg::*;

  logic [2:0]  step;
  logic [2:0]  next_step;
  logic [19:0] count;
  logic [19:0] next_count;
  logic        slowHalf;
  logic        next_slowHalf;

  // ==========================================================================
  // Staircase
  // ==========================================================================
  // A slow, sparse dimming pattern doubles each step so the output cap
  // charges at the low limit.
  always_comb begin
    next_step     = step;
    next_count    = count;
    next_slowHalf = slowHalf;
    if (!start) begin
      next_step     = '0;
      next_count    = '0;
      next_slowHalf = 1'b0;
    end else if (step != ILIM_LAST_STEP || !done) begin
      if (count >= 20'(SS_STEP_CYC - 1)) begin
        next_count = '0;
        if (slowDim && !slowHalf) begin
          next_slowHalf = 1'b1;
        end else begin
          next_slowHalf = 1'b0;
          if (step != ILIM_LAST_STEP) begin
            next_step = step + 3'h1;
          end
        end
      end else begin
        next_count = count + 20'h0_0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      step     <= '0;
      count    <= '0;
      slowHalf <= 1'b0;
    end else begin
      step     <= next_step;
      count    <= next_count;
      slowHalf <= next_slowHalf;
    end
  end

  // Limit is (step+1) times 275 mA, reaching 2.2 A at the top.
  assign limitMa = 12'((13'(step) + 13'h1) * 13'(ILIM_STEP_MA));
  // The last step is doubled too when dimming is slow and sparse.
  assign done    = start && (step == ILIM_LAST_STEP)
                   && (count >= 20'(SS_STEP_CYC - 1))
                   && !(slowDim && !slowHalf);

  final_limit_a: assert property (@(posedge mclk) disable iff (!resetn)
    done |-> limitMa == ILIM_FINAL_MA)
    else $error("soft-start finished below final limit");
endmodule // lfm_softstart
`default_nettype wire

//--- sim/lfm_fault_manager_bench.sv
`default_nettype none
module lfm_fault_manager_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import lfm_pkg::*;

  // ==================
  // Signals
  // ==================
  logic            mclk;
  logic            resetn;
  lfm_sense_t      sense;
  lfm_chan_sense_t chanSense;
  logic [7:0]      regAddr;
  logic            regWrite;
  logic [7:0]      regWdata;
  logic            regRead;
  logic [7:0]      regRdata;
  logic            pwmOnRequest;
  logic            switchGate;
  logic [11:0]     currentLimitMa;
  logic            startCurrentInject;
  logic            inputSwitchOff;
  logic [5:0]      channelEnable;
  int              badCount;
  int              testsRun;
  int              cyc = 0;
  int              t0;
  logic [31:0]     seed;
  logic [7:0]      rv;
  logic [7:0]      m;

  lfm_fault_manager i_lfm_fault_manager (
    .mclk(mclk), .resetn(resetn), .sense(sense), .chanSense(chanSense),
    .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRead(regRead), .regRdata(regRdata), .pwmOnRequest(pwmOnRequest),
    .switchGate(switchGate), .currentLimitMa(currentLimitMa),
    .startCurrentInject(startCurrentInject),
    .inputSwitchOff(inputSwitchOff), .channelEnable(channelEnable)
  );

  lfm_host_model i_lfm_host_model (
    .mclk(mclk), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata)
  );

  // ==================
  // Clock, cycle count, helpers
  // ==================
  // The clock toggles every half period of 20 ns.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // A free cycle count lets waits be measured without extra bookkeeping.
  always @(negedge mclk) begin
    cyc <= cyc + 1;
  end

  // Maximal-length style shift register keeps the random stream repeatable.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic stopTest;
    if (badCount == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==================
  // Watchdog
  // ==================
  // The sequence needs about 45200 cycles; the margin covers slow steps.
  initial begin
    repeat (60000) @(posedge mclk);
    badCount++;
    stopTest();
  end

  // ==================
  // Main sequence
  // ==================
  // Inputs change only on falling edges so rising-edge sampling is clean.
  initial begin
    badCount = 0;
    testsRun = 0;
    seed = 32'h5cb1_6267;
    sense = '0;
    chanSense = '0;
    pwmOnRequest = 1'b1;
    resetn = 1'b0;
    ticks(8);
    chk(32'({regRdata, currentLimitMa, channelEnable}), 0, "rst out");
    chk(32'({switchGate, inputSwitchOff, startCurrentInject}), 0, "rst");
    resetn = 1'b1;
    i_lfm_host_model.rd(ADDR_MASK, rv);
    chk(32'(rv), 32'(RESET_MASK), "mask reset");
    // Mask writes, read-only status and unmapped places, drawn at random.
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      m = seed[7:0] & 8'h3f;
      i_lfm_host_model.wr(ADDR_MASK, m);
      i_lfm_host_model.rd(ADDR_MASK, rv);
      chk(32'(rv), 32'(m), "mask readback");
      i_lfm_host_model.wr(ADDR_FAULT, seed[15:8]);
      i_lfm_host_model.rd(ADDR_FAULT, rv);
      chk(32'(rv), 32'(RESET_FAULT), "status ro");
      m = (seed[23:16] == ADDR_FAULT || seed[23:16] == ADDR_MASK) ?
          8'h5a : seed[23:16];
      i_lfm_host_model.rd(m, rv);
      chk(32'(rv), 0, "unmapped");
    end
    // No switching before the inrush switch is fully on.
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      pwmOnRequest = seed[0];
      ticks(1);
      chk(32'({switchGate, startCurrentInject}), 0, "inrush hold");
    end
    pwmOnRequest = 1'b1;
    sense.inrushSwitchOn = 1'b1;
    ticks(2);
    for (int i = 0; i < 10; i++) begin
      chk(32'({switchGate, startCurrentInject}), 1, "precharge");
      ticks(1);
    end
    sense.switchNodeAbove = 1'b1;
    t0 = cyc;
    ticks(3);
    chk(32'(startCurrentInject), 0, "inject off");
    chk(32'(currentLimitMa), 32'(ILIM_STEP_MA), "first limit");
    // Gate follows the request and is cut by the switch current limit.
    for (int i = 0; i < 200; i++) begin
      seed = lfsr(seed);
      pwmOnRequest = seed[0];
      sense.switchOverLimit = seed[1];
      #1;
      chk(32'(switchGate), 32'(seed[0] & ~seed[1]), "gate");
      ticks(1);
    end
    sense.switchOverLimit = 1'b0;
    pwmOnRequest = 1'b1;
    while (currentLimitMa === ILIM_STEP_MA && cyc - t0 < 30000) ticks(1);
    chk(32'(cyc - t0 >= SS_STEP_CYC), 1, "step too short");
    chk(32'(cyc - t0 <= SS_STEP_CYC + 4), 1, "step too long");
    chk(32'(currentLimitMa), 32'(2 * ILIM_STEP_MA), "second limit");
    // Undervoltage stops switching; restart waits for the inrush switch.
    sense.inputUndervoltageLockout = 1'b1;
    sense.inrushSwitchOn = 1'b0;
    ticks(2);
    chk(32'(switchGate), 0, "input_undervoltage_lockout gate");
    // Channels sit unclassified while stopped, so a fresh mask applies.
    i_lfm_host_model.wr(ADDR_MASK, 8'h20);
    ticks(8);
    sense.inputUndervoltageLockout = 1'b0;
    ticks(5);
    chk(32'({switchGate, startCurrentInject}), 0, "input_undervoltage_lockout hold");
    sense.inrushSwitchOn = 1'b1;
    ticks(6);
    chk(32'(currentLimitMa), 32'(ILIM_STEP_MA), "restart limit");
    chk(32'(switchGate), 1, "restart gate");
    // Channel 5 is masked, channel 0 never reaches its target.
    chanSense.currentAtTarget = 6'h1e;
    ticks(2);
    chk(32'(channelEnable), 32'h1f, "good and masked");
    // Overvoltage limit opens channel 0; six dimming cycles disable it.
    sense.overvoltageAtLimit = 1'b1;
    chanSense.ledStable = 1'b1;
    ticks(2);
    for (int i = 0; i < 6; i++) begin
      chk(32'(channelEnable[0]), 1, "open wait");
      chanSense.dimCycleTick = 1'b1;
      ticks(1);
      chanSense.dimCycleTick = 1'b0;
      ticks(1);
    end
    chk(32'(channelEnable), 32'h1e, "open off");
    sense.overvoltageAtLimit = 1'b0;
    // A short seen while the loop is unsettled must not count.
    chanSense.ledStable = 1'b0;
    chanSense.stringShortDetect = 6'h02;
    ticks(3);
    chk(32'(channelEnable), 32'h1e, "short unsettled");
    chanSense.ledStable = 1'b1;
    ticks(2);
    chk(32'(channelEnable), 32'h1c, "short off");
    chanSense.stringShortDetect = 6'h00;
    // Good channel 2 drops below target while hot: hot open time-out.
    chanSense.currentAtTarget = 6'h1a;
    sense.tempAboveLower = 1'b1;
    ticks(OPEN_HOT_CYC);
    chk(32'(channelEnable), 32'h1c, "hot wait");
    ticks(1);
    chk(32'(channelEnable), 32'h18, "hot off");
    sense.tempAboveLower = 1'b0;
    i_lfm_host_model.rd(ADDR_FAULT, rv);
    chk(32'(rv), 32'h07, "channel faults");
    i_lfm_host_model.rd(ADDR_MASK, rv);
    chk(32'(rv), 32'h27, "failed in mask");
    // The host cannot clear the mask bit of a failed channel.
    i_lfm_host_model.wr(ADDR_MASK, 8'h00);
    i_lfm_host_model.rd(ADDR_MASK, rv);
    chk(32'(rv), 32'h07, "failed stays masked");
    // Input overcurrent while switching shuts every channel down.
    sense.inputOverLimit = 1'b1;
    ticks(2);
    sense.inputOverLimit = 1'b0;
    chk(32'({channelEnable, switchGate}), 0, "overcurrent off");
    // Overvoltage sense rising and falling past 20 % trips the switch.
    sense.overvoltageAbove20 = 1'b1;
    ticks(3);
    chk(32'(inputSwitchOff), 0, "trip early");
    sense.overvoltageAbove20 = 1'b0;
    ticks(2);
    chk(32'({inputSwitchOff, switchGate}), 2, "trip");
    sense.inputOverLimit = 1'b1;
    ticks(2);
    sense.inputOverLimit = 1'b0;
    chk(32'(channelEnable), 0, "shutdown");
    i_lfm_host_model.rd(ADDR_FAULT, rv);
    chk(32'(rv[7:6]), 3, "status input bits");
    // Fault indications stay latched long after the causes have gone.
    ticks(50);
    i_lfm_host_model.rd(ADDR_FAULT, rv);
    chk(32'({rv, inputSwitchOff}), 32'h18f, "latched");
    resetn = 1'b0;
    ticks(2);
    resetn = 1'b1;
    i_lfm_host_model.rd(ADDR_FAULT, rv);
    chk(32'({rv, inputSwitchOff}), 0, "reset clears");
    stopTest();
  end
endmodule // lfm_fault_manager_bench
`default_nettype wire

//--- sim/lfm_host_model.sv
`default_nettype none
// ==================
// Host register master
// ==================
module lfm_host_model (
  // Clock
  input  wire logic       mclk,
  // Register port
  output logic [7:0]      regAddr,
  output logic            regWrite,
  output logic [7:0]      regWdata,
  output logic            regRead,
  input  wire logic [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // The port is idle and quiet until the first access.
  initial begin
    regAddr  = 8'h00;
    regWrite = 1'b0;
    regWdata = 8'h00;
    regRead  = 1'b0;
  end

  // One write; an idle port shows inverted values so stale data never helps.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
    regAddr  = ~a;
    regWdata = ~d;
  endtask

  // One read; data is taken one clock after the request.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge mclk);
    regRead = 1'b0;
    regAddr = ~a;
    d       = regRdata;
  endtask
endmodule // lfm_host_model
`default_nettype wire
